// File: verilog/cdie_top.sv
// Instruction executor of a character display controller, APB slave.
// Assumes a single 200 MHz clock, synchronous reset and APB master outside.
//
// Local design decisions: register access over APB and the placing of the registers.
`include "cdie_params.svh"
`default_nettype none

module cdie_top #(
  parameter int BLINK_HALF_CYCLES = `CDIE_BLINK_HALF_NS / `CDIE_CLK_PERIOD_NS,
  parameter int EXEC_CYCLES =
    (`CDIE_EXEC_NS + `CDIE_CLK_PERIOD_NS - 1) / `CDIE_CLK_PERIOD_NS,
  parameter int PWM_STEP_CYCLES = `CDIE_PWM_STEP_NS / `CDIE_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Register bus
  input wire cdie_pkg::cdie_apb_req_type APB_REQ_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Display drive
  output logic [79:0] ANODE_O,
  output logic DISPLAY_ON_O,
  output logic CURSOR_ON_O,
  output logic CURSOR_ALL_ON_O,
  output logic [6:0] CURSOR_ADDR_O,
  output logic [6:0] SHIFT_OFFSET_O,
  // Status
  output logic BUS_8BIT_O,
  output logic BUSY_O
);
  import cdie_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // Pattern RAM addresses live in the low 6 bits and wrap there
  function automatic logic [6:0] step_acc(input logic [6:0] a, input logic up,
                                          input logic pat);
    logic [6:0] n;
    n = up ? a + 7'h01 : a - 7'h01;
    step_acc = pat ? {1'b0, n[5:0]} : n;
  endfunction

  // Display offset: left shifts count up, right shifts down, modulo 128
  function automatic logic [6:0] step_ofs(input logic [6:0] o, input logic left);
    step_ofs = left ? o + 7'h01 : o - 7'h01;
  endfunction

  // ****************************************
  // State and memories
  // ****************************************
  cdie_regs_type r;
  cdie_regs_type next_r;
  logic [7:0] text_ram [0:127];
  logic [7:0] pattern_ram [0:63];
  logic text_we;
  logic [6:0] text_waddr;
  logic [7:0] text_wdata;
  logic pat_we;
  logic [5:0] pat_waddr;
  logic [7:0] pat_wdata;

  logic busy;
  logic done;
  logic wr;
  logic rd;
  logic go;
  logic [7:0] code;
  logic [7:0] ram_q;
  logic [31:0] mode_word;
  logic [2:0] on_quarters;
  logic lit;

  logic hit_cmd;
  logic hit_data;
  logic hit_mode;
  logic pwm_tick;
  logic blink_tick;

  assign busy = r.busy;
  assign done = APB_REQ_I.psel & APB_REQ_I.penable & r.pready;
  assign wr = done & APB_REQ_I.pwrite & ~busy;
  assign rd = done & ~APB_REQ_I.pwrite & ~busy;
  assign ram_q = r.sel_pattern ? pattern_ram[r.acc[5:0]] : text_ram[r.acc];
  assign on_quarters = 3'h4 - {1'b0, r.bright};
  assign lit = r.disp_on & ({1'b0, r.pwm_phase} < on_quarters);

  // ****************************************
  // Register decode
  // ****************************************
  // Exact byte compare; any other offset gets the error answer
  always_comb begin
    hit_cmd = 1'b0;
    hit_data = 1'b0;
    hit_mode = 1'b0;
    if (APB_REQ_I.paddr == `CDIE_OFS_CMD) begin
      hit_cmd = 1'b1;
    end else if (APB_REQ_I.paddr == `CDIE_OFS_DATA) begin
      hit_data = 1'b1;
    end else if (APB_REQ_I.paddr == `CDIE_OFS_MODE) begin
      hit_mode = 1'b1;
    end
  end

  // ****************************************
  // Timebase enables
  // ****************************************
  // One-cycle pulses from the dividers; nothing runs on a second clock
  assign pwm_tick = (r.pwm_div == 16'(PWM_STEP_CYCLES - 1));
  assign blink_tick = (r.blink_cnt == 32'(BLINK_HALF_CYCLES - 1));

  always_comb begin
    mode_word = 32'h0;
    mode_word[`CDIE_MODE_DISP_BIT] = r.disp_on;
    mode_word[`CDIE_MODE_CUR_BIT] = r.cur_on;
    mode_word[`CDIE_MODE_BLINK_BIT] = r.blink_on;
    mode_word[`CDIE_MODE_INC_BIT] = r.inc;
    mode_word[`CDIE_MODE_SHIFT_BIT] = r.shift_en;
    mode_word[`CDIE_MODE_W8_BIT] = r.width8;
    mode_word[`CDIE_MODE_TWO_BIT] = r.two_line;
    mode_word[`CDIE_MODE_PAT_BIT] = r.sel_pattern;
    mode_word[`CDIE_MODE_BR_LSB +: 2] = r.bright;
    mode_word[`CDIE_MODE_NIB_BIT] = r.nib_pending;
    mode_word[`CDIE_MODE_OFS_LSB +: 7] = r.shift_ofs;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    text_we = 1'b0;
    text_waddr = r.fill_addr;
    text_wdata = `CDIE_BLANK_CODE;
    pat_we = 1'b0;
    pat_waddr = r.acc[5:0];
    pat_wdata = 8'h00;
    go = 1'b0;
    code = APB_REQ_I.pwdata[7:0];

    // Bus answer one cycle into the access phase
    next_r.pready = APB_REQ_I.psel & APB_REQ_I.penable & ~r.pready;
    next_r.pslverr = 1'b0;
    if (APB_REQ_I.psel & APB_REQ_I.penable & ~r.pready) begin
      next_r.prdata = 32'h0;
      if (hit_cmd) begin
        next_r.prdata[`CDIE_STAT_BUSY_BIT] = busy;
        next_r.prdata[6:0] = r.acc;
      end else if (hit_data) begin
        next_r.prdata[7:0] = ram_q;
      end else if (hit_mode) begin
        next_r.prdata = mode_word;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end

    // Sequencer
    case (r.state)
      CDIE_CLEAR: begin
        text_we = 1'b1;
        next_r.fill_addr = r.fill_addr + 7'h01;
        if (r.fill_addr == 7'h7f) begin
          next_r.state = CDIE_IDLE;
        end
      end
      CDIE_EXEC: begin
        next_r.exec_cnt = r.exec_cnt - 16'h1;
        if (r.exec_cnt == 16'h0) begin
          next_r.state = CDIE_IDLE;
        end
      end
      default: begin
      end
    endcase

    // Nibble pairing: high nibble first, both on bits 7..4
    if (wr && (hit_cmd || hit_data)) begin
      if (r.width8) begin
        go = 1'b1;
      end else if (!r.nib_pending) begin
        next_r.nib_pending = 1'b1;
        next_r.nib_hi = APB_REQ_I.pwdata[7:4];
      end else begin
        go = 1'b1;
        code = {r.nib_hi, APB_REQ_I.pwdata[7:4]};
        next_r.nib_pending = 1'b0;
      end
    end

    if (go) begin
      next_r.state = CDIE_EXEC;
      next_r.exec_cnt = 16'(EXEC_CYCLES - 1);
    end

    if (go && hit_cmd) begin
      if (code[7]) begin
        next_r.acc = code[6:0];
        next_r.sel_pattern = 1'b0;
      end else if (code[6]) begin
        next_r.acc = {1'b0, code[5:0]};
        next_r.sel_pattern = 1'b1;
      end else if (code[5]) begin
        next_r.width8 = code[4];
        next_r.two_line = code[3];
        next_r.bright = code[1:0];
        next_r.nib_pending = 1'b0;
      end else if (code[4]) begin
        // Display RAM only; the low two bits carry nothing
        next_r.acc = step_acc(r.acc, code[2], 1'b0);
        if (code[3]) begin
          next_r.shift_ofs = step_ofs(r.shift_ofs, ~code[2]);
        end
        next_r.sel_pattern = 1'b0;
      end else if (code[3]) begin
        next_r.disp_on = code[2];
        next_r.cur_on = code[1];
        next_r.blink_on = code[0];
      end else if (code[2]) begin
        next_r.inc = code[1];
        next_r.shift_en = code[0];
      end else if (code[1]) begin
        next_r.acc = 7'h00;
        next_r.sel_pattern = 1'b0;
        next_r.shift_ofs = 7'h00;
      end else if (code[0]) begin
        next_r.state = CDIE_CLEAR;
        next_r.fill_addr = 7'h00;
        next_r.acc = 7'h00;
        next_r.sel_pattern = 1'b0;
        next_r.shift_ofs = 7'h00;
        next_r.inc = 1'b1;
      end
    end

    // Data access: write stores and steps, read steps
    if (go && hit_data) begin
      next_r.acc = step_acc(r.acc, r.inc, r.sel_pattern);
      if (r.sel_pattern) begin
        pat_we = 1'b1;
        pat_wdata = code;
      end else begin
        text_we = 1'b1;
        text_waddr = r.acc;
        text_wdata = code;
        if (r.shift_en) begin
          // Display moves against the counter so the cursor stays put
          next_r.shift_ofs = step_ofs(r.shift_ofs, r.inc);
        end
      end
    end
    if (rd && hit_data) begin
      next_r.acc = step_acc(r.acc, r.inc, r.sel_pattern);
    end

    // Blink timebase only runs while blink is on
    if (r.blink_on) begin
      next_r.blink_cnt = r.blink_cnt + 32'h1;
      if (blink_tick) begin
        next_r.blink_cnt = 32'h0;
        next_r.blink_phase = ~r.blink_phase;
      end
    end else begin
      next_r.blink_cnt = 32'h0;
      next_r.blink_phase = 1'b0;
    end

    // Brightness quarters, stepped by a divider enable
    next_r.pwm_div = r.pwm_div + 16'h1;
    if (pwm_tick) begin
      next_r.pwm_div = 16'h0;
      next_r.pwm_phase = r.pwm_phase + 2'h1;
    end
    next_r.anode = {(r.two_line & lit) ? 40'hff_ffff_ffff : 40'h0,
                    lit ? 40'hff_ffff_ffff : 40'h0};
    // Busy kept in its own flop so the status pin comes from a register
    next_r.busy = (next_r.state != CDIE_IDLE);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      // Reset runs a clear, so busy stays up while RAM fills
      r <= '0;
      r.state <= CDIE_CLEAR;
      r.busy <= 1'b1;
      r.inc <= `CDIE_RST_INC;
      r.width8 <= `CDIE_RST_W8;
      r.two_line <= `CDIE_RST_TWO;
      r.bright <= `CDIE_RST_BR;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (text_we) begin
      text_ram[text_waddr] <= text_wdata;
    end
    if (pat_we) begin
      pattern_ram[pat_waddr] <= pat_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PRDATA_O = r.prdata;
  assign PREADY_O = r.pready;
  assign PSLVERR_O = r.pslverr;
  assign ANODE_O = r.anode;
  assign DISPLAY_ON_O = r.disp_on;
  assign CURSOR_ON_O = r.cur_on;
  assign CURSOR_ALL_ON_O = r.blink_phase;
  assign CURSOR_ADDR_O = r.acc;
  assign SHIFT_OFFSET_O = r.shift_ofs;
  assign BUS_8BIT_O = r.width8;
  assign BUSY_O = r.busy;

endmodule

`default_nettype wire

// File: include/cdie_params.svh
// Constants for the character display instruction executor.
// Assumes a 200 MHz core clock and a 32-bit APB register window.
`ifndef CDIE_PARAMS_SVH
`define CDIE_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CDIE_OFS_CMD 8'h00
`define CDIE_OFS_DATA 8'h04
`define CDIE_OFS_MODE 8'h08

// ****************************************
// Field positions
// ****************************************
`define CDIE_STAT_BUSY_BIT 7
`define CDIE_MODE_DISP_BIT 0
`define CDIE_MODE_CUR_BIT 1
`define CDIE_MODE_BLINK_BIT 2
`define CDIE_MODE_INC_BIT 3
`define CDIE_MODE_SHIFT_BIT 4
`define CDIE_MODE_W8_BIT 5
`define CDIE_MODE_TWO_BIT 6
`define CDIE_MODE_PAT_BIT 7
`define CDIE_MODE_BR_LSB 8
`define CDIE_MODE_NIB_BIT 10
`define CDIE_MODE_OFS_LSB 16

// ****************************************
// Reset values and codes
// ****************************************
`define CDIE_BLANK_CODE 8'h20
`define CDIE_RST_INC 1'b1
`define CDIE_RST_W8 1'b1
`define CDIE_RST_TWO 1'b1
`define CDIE_RST_BR 2'h0

// ****************************************
// Timing
// ****************************************
`define CDIE_CLK_PERIOD_NS 5
`define CDIE_EXEC_NS 1000
`define CDIE_BLINK_HALF_NS 500000000
`define CDIE_PWM_STEP_NS 320

`endif

// File: include/cdie_pkg.sv
// Types shared by the instruction executor.
// Assumes cdie_params.svh sits on the include path.
`default_nettype none

package cdie_pkg;

  // ****************************************
  // Bus request
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cdie_apb_req_type;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    CDIE_IDLE = 3'b001,
    CDIE_CLEAR = 3'b010,
    CDIE_EXEC = 3'b100
  } cdie_state_type;

  // ****************************************
  // Register state of the executor; the text and pattern RAMs sit outside it
  // ****************************************
  typedef struct packed {
    cdie_state_type state;
    logic busy;
    logic [15:0] exec_cnt;
    logic [6:0] fill_addr;
    logic [6:0] acc;
    logic sel_pattern;
    logic inc;
    logic shift_en;
    logic disp_on;
    logic cur_on;
    logic blink_on;
    logic width8;
    logic two_line;
    logic [1:0] bright;
    logic [6:0] shift_ofs;
    logic nib_pending;
    logic [3:0] nib_hi;
    logic [31:0] blink_cnt;
    logic blink_phase;
    logic [15:0] pwm_div;
    logic [1:0] pwm_phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [79:0] anode;
  } cdie_regs_type;

endpackage

`default_nettype wire

// File: verif/cdie_host.sv
// Host model: APB master that polls busy before each instruction.
// Assumes one clock shared with the executor.
`default_nettype none
module cdie_host (
  // Clock
  input wire logic clk_i,
  // Register bus
  output var cdie_pkg::cdie_apb_req_type req_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import cdie_pkg::*;
  logic nib = 1'b0;
  initial req_o = '0;
  // ****************************************
  // Transfers
  // ****************************************
  // Released address and data lines show inverted values; pwrite keeps its last one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    er = pslverr_i;
    req_o <= '{1'b0, 1'b0, w, ~a, ~d};
  endtask
  // Busy is polled only before the high nibble
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] b,
                    output logic [31:0] rd);
    logic e;
    do xfer(1'b0, 8'h00, 32'h0, rd, e); while (rd[7] !== 1'b0);
    if (w && nib) begin
      xfer(1'b1, a, {24'h0, b[7:4], 4'h5}, rd, e);
      xfer(1'b1, a, {24'h0, b[3:0], 4'ha}, rd, e);
    end else begin
      xfer(w, a, {24'h0, b}, rd, e);
    end
    if (w && a == 8'h00 && b[7:5] == 3'b001) nib = !b[4];
  endtask
endmodule
`default_nettype wire

// File: verif/cdie_monitor.sv
// Port checker for the instruction executor.
// Assumes it is bound onto cdie_top.
`default_nettype none
module cdie_monitor (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Register bus
  input wire cdie_pkg::cdie_apb_req_type APB_REQ_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Display drive
  input wire logic [79:0] ANODE_O,
  input wire logic DISPLAY_ON_O,
  input wire logic CURSOR_ON_O,
  input wire logic CURSOR_ALL_ON_O,
  input wire logic [6:0] CURSOR_ADDR_O,
  input wire logic [6:0] SHIFT_OFFSET_O,
  // Status
  input wire logic BUS_8BIT_O,
  input wire logic BUSY_O
);
  timeunit 1ns;
  timeprecision 100ps;
  import cdie_pkg::*;
  logic acs;
  logic wr;
  logic take;
  assign acs = APB_REQ_I.psel & APB_REQ_I.penable;
  assign wr = acs & PREADY_O & APB_REQ_I.pwrite;
  // Nibble halves excluded: one half alone never executes
  assign take = wr & (APB_REQ_I.paddr == 8'h00) & !BUSY_O & BUS_8BIT_O;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
  wait_state_a: assert property (acs && !PREADY_O |=> PREADY_O) else $error("ready late");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  instr_busy_a: assert property (take |=> BUSY_O) else $error("busy not raised");
  busy_ignore_a: assert property (wr && APB_REQ_I.paddr == 8'h00 && BUSY_O |=>
    $stable(CURSOR_ADDR_O) && $stable(DISPLAY_ON_O)) else $error("write taken while busy");
  addr_load_a: assert property (take && APB_REQ_I.pwdata[7] |=>
    CURSOR_ADDR_O == $past(APB_REQ_I.pwdata[6:0])) else $error("address not loaded");
  disp_ctl_a: assert property (take && APB_REQ_I.pwdata[7:3] == 5'h01 |=>
    DISPLAY_ON_O == $past(APB_REQ_I.pwdata[2]) && CURSOR_ON_O == $past(APB_REQ_I.pwdata[1]))
    else $error("display control not latched");
  home_clear_a: assert property (take && APB_REQ_I.pwdata[7:2] == 6'h00 &&
    APB_REQ_I.pwdata[1:0] != 2'h0 |=> CURSOR_ADDR_O == 7'h00 && SHIFT_OFFSET_O == 7'h00)
    else $error("not homed");
  dark_anode_a: assert property (!DISPLAY_ON_O [*3] |-> ANODE_O == 80'h0)
    else $error("anodes lit while off");
endmodule
bind cdie_top cdie_monitor i_cdie_monitor (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .APB_REQ_I(APB_REQ_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .ANODE_O(ANODE_O), .DISPLAY_ON_O(DISPLAY_ON_O), .CURSOR_ON_O(CURSOR_ON_O),
  .CURSOR_ALL_ON_O(CURSOR_ALL_ON_O), .CURSOR_ADDR_O(CURSOR_ADDR_O),
  .SHIFT_OFFSET_O(SHIFT_OFFSET_O), .BUS_8BIT_O(BUS_8BIT_O), .BUSY_O(BUSY_O));
`default_nettype wire

// File: verif/cdie_top_test.sv
// Self-checking bench for the instruction executor.
// Assumes the host model drives the bus; long counts are shortened.
`default_nettype none
module cdie_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cdie_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cdie_apb_req_type req;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [79:0] anode;
  logic [6:0] cadr;
  logic [6:0] sofs;
  logic [6:0] a;
  logic [6:0] o;
  logic [15:0] lf = 16'h1101;
  logic pready, perr, dsp, cur, blk, w8, busy, e;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int k;
  int hc[3];
  always #2.5 clk = ~clk;
  cdie_top #(.BLINK_HALF_CYCLES(8), .EXEC_CYCLES(12), .PWM_STEP_CYCLES(2)) i_cdie_top (
    .CLOCK_I(clk), .RST_I(rst), .APB_REQ_I(req), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(perr), .ANODE_O(anode), .DISPLAY_ON_O(dsp), .CURSOR_ON_O(cur),
    .CURSOR_ALL_ON_O(blk), .CURSOR_ADDR_O(cadr), .SHIFT_OFFSET_O(sofs), .BUS_8BIT_O(w8),
    .BUSY_O(busy));
  cdie_host i_cdie_host (.clk_i(clk), .req_o(req), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(perr));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [6:0] stp(input logic [6:0] v, input logic up);
    return up ? v + 7'h01 : v - 7'h01;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    checked++;
    if (gt !== ex) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] ad, input logic [7:0] b);
    i_cdie_host.op(1'b1, ad, b, rd);
    @(negedge clk);
  endtask
  task automatic get(input logic [7:0] ad);
    i_cdie_host.op(1'b0, ad, 8'h00, rd);
    @(negedge clk);
  endtask
  // Skips the anode latency, then counts highs
  task automatic count(input int n);
    hc = '{0, 0, 0};
    repeat (3) @(negedge clk);
    repeat (n) begin
      @(negedge clk);
      hc[0] += int'(anode[0]);
      hc[1] += int'(anode[40]);
      hc[2] += int'(blk);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    get(8'h08);
    chk("reset mode", 32'h68, rd);
    put(8'h00, 8'h38);
    for (k = 0; k < 4; k++) begin
      lf = nxt(lf);
      a = {k[1:0], 2'b00, lf[2:0]};
      put(8'h00, {1'b1, a});
      get(8'h04);
      chk("blank", 32'h20, rd);
      chk("read step", stp(a, 1'b1), cadr);
      put(8'h00, {1'b1, a});
      put(8'h04, lf[15:8]);
      put(8'h00, {1'b1, a});
      get(8'h04);
      chk("ram", lf[15:8], rd);
    end
    $display("ram test done");
    o = 7'h00;
    for (k = 0; k < 4; k++) begin
      put(8'h00, 8'h04 | 8'(k));
      put(8'h00, 8'h90);
      put(8'h04, 8'h41);
      chk("wr acc", stp(7'h10, k[1]), cadr);
      if (k[0]) o = stp(o, k[1]);
      chk("wr ofs", o, sofs);
      get(8'h04);
      chk("rd acc", stp(stp(7'h10, k[1]), k[1]), cadr);
      chk("rd ofs", o, sofs);
    end
    $display("entry test done");
    for (k = 8; k < 16; k++) begin
      put(8'h00, 8'(k));
      get(8'h08);
      chk("ctl", k[2:0], {dsp, cur, rd[2]});
    end
    count(32);
    chk("blink", 16, hc[2]);
    put(8'h00, 8'h0c);
    for (k = 0; k < 8; k++) begin
      put(8'h00, {4'h3, k[2], 1'b0, k[1:0]});
      count(64);
      chk("duty", 16 * (4 - k[1:0]), hc[0]);
      chk("upper", k[2] ? 16 * (4 - k[1:0]) : 0, hc[1]);
      chk("no blink", 0, hc[2]);
    end
    $display("control test done");
    put(8'h00, 8'h02);
    a = 7'h00;
    o = 7'h00;
    for (k = 16; k < 32; k++) begin
      put(8'h00, 8'(k));
      a = stp(a, k[2]);
      if (k[3]) o = stp(o, !k[2]);
      chk("sh acc", a, cadr);
      chk("sh ofs", o, sofs);
    end
    put(8'h00, 8'h18);
    put(8'h00, 8'h03);
    chk("home", 0, {cadr, sofs});
    put(8'h00, 8'h07);
    put(8'h00, 8'h7f);
    put(8'h04, lf[7:0]);
    get(8'h08);
    chk("pat sel", 1, rd[7]);
    chk("pat wrap", 0, cadr);
    chk("pat ofs", 0, sofs);
    put(8'h00, 8'h7f);
    get(8'h04);
    chk("pat ram", lf[7:0], rd);
    chk("pat rd wrap", 0, cadr);
    $display("shift test done");
    put(8'h00, 8'h05);
    put(8'h00, 8'h85);
    put(8'h04, 8'h55);
    put(8'h00, 8'h01);
    get(8'h08);
    chk("clr mode", 32'h08, rd & 32'h88);
    chk("clr acc", 0, {cadr, sofs});
    put(8'h00, 8'h85);
    get(8'h04);
    chk("clr fill", 32'h20, rd);
    put(8'h00, 8'h80);
    i_cdie_host.xfer(1'b0, 8'h00, 32'h0, rd, e);
    chk("busy", 1, rd[7]);
    @(negedge clk);
    chk("busy pin", 1, busy);
    i_cdie_host.xfer(1'b1, 8'h00, 32'hb3, rd, e);
    @(negedge clk);
    chk("ignored", 0, cadr);
    i_cdie_host.xfer(1'b0, 8'h0c, 32'h0, rd, e);
    chk("unmapped", 1, e);
    $display("busy test done");
    put(8'h00, 8'h28);
    chk("w4", 0, w8);
    lf = nxt(lf);
    put(8'h00, {1'b1, lf[6:0]});
    chk("nib addr", lf[6:0], cadr);
    put(8'h00, 8'h38);
    chk("w8", 1, w8);
    $display("nibble test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
